// ### unb_uart.sv
/*
 * Nine-bit asynchronous serial port: Avalon-MM register slave, transmitter,
 * receiver with hidden receive baud timer and one-byte receive buffer.
 * Assumes the external baud timer delivers its count enable, run bit,
 * low-byte overflow pulse and reload byte synchronous to mclk_in, and that
 * the serial and logic-unit inputs are synchronous to mclk_in.
 */
// Overview of operation
// - Data address writes load transmit holding; reads return receive buffer only.
// - Done flags stay set until software writes the control register.
// - Interrupt request raised while enabled and either done flag is set.
// - Transmit timing from timer overflows; receive uses private timer copy.
// - Each overflow stream is divided by two for one bit period.
// - Receive timer runs only with timer run, reloading from the reload byte.
// - Start detection reloads the receive timer, aligning reception to it.
// - Frames: low start bit, data LSB first, high stop bit.
// - Mode bit selects eight data bits or nine with ninth after MSB.
// - Data write starts transmission; ninth bit taken from control at write.
// - Transmit-done flag sets when the stop bit begins.
// - Reception only while receive enable is one; bits sampled at baud.
// - Frame buffered only with room and address filter satisfied.
// - Filter on: accept only if stop or ninth bit is one.
// - Buffer full: new frame dropped, old byte kept.
// - Receive-done flag sets on each frame pushed into the buffer.
// - Receive ninth status holds ninth bit, or stop bit in eight-bit mode.
// - One buffered byte lets the next frame arrive before software reads.
// - Receive input from pin or one of three logic-unit outputs.
// - Transmit and receive each up to half of system clock.
`timescale 1ns/100ps
`include "unb_consts.svh"

module unb_uart (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic serial_rx_input_in,
   input wire logic [2:0] clu_rx_in,
   input wire logic timer_run_in,
   input wire logic timer_tick_in,
   input wire logic baud_timer_low_byte_ovf_in,
   input wire logic [7:0] baud_timer_reload_byte_in,
   output logic txd_out,
   output logic irq_out
);

   // ----------------------------------------------------------------------
   // State and decoded strobes
   // ----------------------------------------------------------------------
   unb_pkg::unb_state_t st_r;
   unb_pkg::unb_state_t st_nxt;
   logic req;
   logic commit;
   logic wr_ctrl;
   logic wr_data;
   logic wr_pcf;
   logic rd_data;
   logic tx_tick;
   logic rx_ovf;
   logic rx_sample;
   logic start_det;
   logic rx_pin;
   logic [3:0] nbits;
   logic frame_ninth;
   logic push_try;
   logic push;
   logic [31:0] rd_mux;

   // Bus decode; the access completes at the edge where st_r.ack is high
   assign req = avs_read_in | avs_write_in;
   assign commit = req & st_r.ack;
   assign wr_ctrl = commit & avs_write_in & avs_byteenable_in[0]
                    & (avs_address_in == `UNB_OFS_CTRL);
   assign wr_data = commit & avs_write_in & avs_byteenable_in[0]
                    & (avs_address_in == `UNB_OFS_DATA);
   assign wr_pcf = commit & avs_write_in & avs_byteenable_in[0]
                   & (avs_address_in == `UNB_OFS_PINCFG);
   assign rd_data = commit & avs_read_in & (avs_address_in == `UNB_OFS_DATA);

   // Bit tick is every second timer overflow
   assign tx_tick = baud_timer_low_byte_ovf_in & st_r.tx_div;

   // Hidden receive timer overflows and mid-bit sample points
   assign rx_ovf = timer_run_in & timer_tick_in
                   & (st_r.rx_timer == `UNB_TIMER_TOP);
   assign rx_sample = rx_ovf & ~st_r.rx_phase;
   assign start_det = st_r.rx_en & (st_r.rx_state == unb_pkg::RX_IDLE)
                      & st_r.rx_prev & ~st_r.rx_s2;

   // Receive source select
   always_comb begin
      unique case (st_r.rx_source_select)
         `UNB_SRC_PIN: rx_pin = serial_rx_input_in;
         `UNB_SRC_CLU_A: rx_pin = clu_rx_in[0];
         `UNB_SRC_CLU_B: rx_pin = clu_rx_in[1];
         `UNB_SRC_CLU_C: rx_pin = clu_rx_in[2];
      endcase
   end

   // Frame length, filter bit and buffer push decision
   assign nbits = st_r.ninth_bit_select ? `UNB_BITS_9 : `UNB_BITS_8;
   assign frame_ninth = st_r.ninth_bit_select ? st_r.rx_sh[8] : st_r.rx_s2;
   assign push_try = rx_sample & (st_r.rx_state == unb_pkg::RX_STOP);
   assign push = push_try & ~st_r.rx_full
                 & (~st_r.addr_filter_enable | frame_ninth);

   // Read multiplexer; the transmit holding register is never visible
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address_in)
         `UNB_OFS_CTRL: begin
            rd_mux[`UNB_CTRL_RX_DONE] = st_r.rx_done_flag;
            rd_mux[`UNB_CTRL_TX_DONE] = st_r.tx_done_flag;
            rd_mux[`UNB_CTRL_RX_NINTH] = st_r.rx_ninth_bit;
            rd_mux[`UNB_CTRL_TX_NINTH] = st_r.tx_ninth_bit;
            rd_mux[`UNB_CTRL_RX_EN] = st_r.rx_en;
            rd_mux[`UNB_CTRL_AFE] = st_r.addr_filter_enable;
            rd_mux[`UNB_CTRL_INT_EN] = st_r.int_en;
            rd_mux[`UNB_CTRL_NINE_SEL] = st_r.ninth_bit_select;
         end
         `UNB_OFS_DATA: rd_mux[7:0] = st_r.rx_buf;
         `UNB_OFS_PINCFG: rd_mux[`UNB_PCF_SRC_HI:`UNB_PCF_SRC_LO] = st_r.rx_source_select;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;

      // Bus slave: one wait cycle, then commit
      st_nxt.ack = req & ~st_r.ack;
      if (req & ~st_r.ack) begin
         st_nxt.rdata = rd_mux;
      end

      // Software writes; hardware sets below override a clear
      if (wr_ctrl) begin
         st_nxt.rx_done_flag = avs_writedata_in[`UNB_CTRL_RX_DONE];
         st_nxt.tx_done_flag = avs_writedata_in[`UNB_CTRL_TX_DONE];
         st_nxt.tx_ninth_bit = avs_writedata_in[`UNB_CTRL_TX_NINTH];
         st_nxt.rx_en = avs_writedata_in[`UNB_CTRL_RX_EN];
         st_nxt.addr_filter_enable = avs_writedata_in[`UNB_CTRL_AFE];
         st_nxt.int_en = avs_writedata_in[`UNB_CTRL_INT_EN];
         st_nxt.ninth_bit_select = avs_writedata_in[`UNB_CTRL_NINE_SEL];
      end
      if (wr_pcf) begin
         st_nxt.rx_source_select = avs_writedata_in[`UNB_PCF_SRC_HI:`UNB_PCF_SRC_LO];
      end

      // Transmit overflow divider
      st_nxt.tx_div = st_r.tx_div ^ baud_timer_low_byte_ovf_in;

      // Transmitter
      if (tx_tick) begin
         unique case (st_r.tx_state)
            unb_pkg::TX_IDLE: begin
               if (st_r.tx_pend) begin
                  st_nxt.tx_state = unb_pkg::TX_START;
                  st_nxt.txd = 1'b0;
                  st_nxt.tx_sh = st_r.tx_hold;
                  st_nxt.tx_pend = 1'b0;
               end
            end
            unb_pkg::TX_START: begin
               st_nxt.tx_state = unb_pkg::TX_DATA;
               st_nxt.txd = st_r.tx_sh[0];
               st_nxt.tx_sh = {1'b0, st_r.tx_sh[8:1]};
               st_nxt.tx_cnt = 4'h1;
            end
            unb_pkg::TX_DATA: begin
               if (st_r.tx_cnt == nbits) begin
                  st_nxt.tx_state = unb_pkg::TX_STOP;
                  st_nxt.txd = 1'b1;
                  st_nxt.tx_done_flag = 1'b1;
               end else begin
                  st_nxt.txd = st_r.tx_sh[0];
                  st_nxt.tx_sh = {1'b0, st_r.tx_sh[8:1]};
                  st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
               end
            end
            unb_pkg::TX_STOP: begin
               st_nxt.tx_state = unb_pkg::TX_IDLE;
               st_nxt.txd = 1'b1;
            end
         endcase
      end

      // Data write loads the holding register with the ninth bit
      if (wr_data) begin
         st_nxt.tx_hold = {st_r.tx_ninth_bit, avs_writedata_in[7:0]};
         st_nxt.tx_pend = 1'b1;
      end

      // Receive synchroniser
      st_nxt.rx_s1 = rx_pin;
      st_nxt.rx_s2 = st_r.rx_s1;
      st_nxt.rx_prev = st_r.rx_s2;

      // Hidden receive timer
      if (start_det) begin
         st_nxt.rx_timer = baud_timer_reload_byte_in;
         st_nxt.rx_phase = 1'b0;
      end else if (timer_run_in & timer_tick_in) begin
         if (rx_ovf) begin
            st_nxt.rx_timer = baud_timer_reload_byte_in;
            st_nxt.rx_phase = ~st_r.rx_phase;
         end else begin
            st_nxt.rx_timer = st_r.rx_timer + 8'h01;
         end
      end

      // Receiver
      if (~st_r.rx_en) begin
         st_nxt.rx_state = unb_pkg::RX_IDLE;
      end else begin
         unique case (st_r.rx_state)
            unb_pkg::RX_IDLE: begin
               if (start_det) begin
                  st_nxt.rx_state = unb_pkg::RX_START;
               end
            end
            unb_pkg::RX_START: begin
               if (rx_sample) begin
                  st_nxt.rx_state = st_r.rx_s2 ? unb_pkg::RX_IDLE : unb_pkg::RX_DATA;
                  st_nxt.rx_cnt = 4'h0;
               end
            end
            unb_pkg::RX_DATA: begin
               if (rx_sample) begin
                  st_nxt.rx_sh[st_r.rx_cnt] = st_r.rx_s2;
                  st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
                  if (st_r.rx_cnt == nbits - 4'h1) begin
                     st_nxt.rx_state = unb_pkg::RX_STOP;
                  end
               end
            end
            unb_pkg::RX_STOP: begin
               if (rx_sample) begin
                  st_nxt.rx_state = unb_pkg::RX_IDLE;
               end
            end
         endcase
      end

      // Buffer read frees the slot; a push in the same cycle wins
      // A frame landing in the wait cycle of a data read is freed unread,
      // so software reads the buffer only after seeing receive-done
      if (rd_data) begin
         st_nxt.rx_full = 1'b0;
      end
      if (push) begin
         st_nxt.rx_buf = st_r.rx_sh[7:0];
         st_nxt.rx_ninth_bit = frame_ninth;
         st_nxt.rx_full = 1'b1;
         st_nxt.rx_done_flag = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         st_r <= '0;
         st_r.txd <= `UNB_RST_TXD;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign avs_readdata_out = st_r.rdata;
   assign avs_waitrequest_out = req & ~st_r.ack;
   assign txd_out = st_r.txd;
   assign irq_out = st_r.int_en & (st_r.tx_done_flag | st_r.rx_done_flag);

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   idle_line_high_a: assert property (
      (st_r.tx_state == unb_pkg::TX_IDLE) |-> txd_out)
      else $error("transmit line low while idle");

   start_bit_low_a: assert property (
      (st_r.tx_state == unb_pkg::TX_START) |-> !txd_out)
      else $error("start bit not low");

   tx_done_at_stop_a: assert property (
      (st_r.tx_state == unb_pkg::TX_DATA) && tx_tick && (st_r.tx_cnt == nbits)
      |=> (st_r.tx_state == unb_pkg::TX_STOP) && st_r.tx_done_flag && txd_out)
      else $error("transmit-done not set at stop bit start");

   flags_sticky_a: assert property (
      st_r.rx_done_flag && !wr_ctrl |=> st_r.rx_done_flag)
      else $error("receive-done cleared without software write");

   irq_follows_a: assert property (
      $rose(st_r.rx_done_flag) && st_r.int_en |-> irq_out)
      else $error("no interrupt on receive-done");

   full_keeps_byte_a: assert property (
      push_try && st_r.rx_full && !rd_data |=> $stable(st_r.rx_buf) && st_r.rx_full)
      else $error("buffered byte overwritten while full");

   filter_check_a: assert property (
      push_try && st_r.addr_filter_enable
      && !(st_r.ninth_bit_select ? st_r.rx_sh[8] : st_r.rx_s2)
      |=> $stable(st_r.rx_buf) && $stable(st_r.rx_ninth_bit))
      else $error("frame accepted with filter bit zero");

   push_sets_flag_a: assert property (
      push |=> st_r.rx_done_flag && (st_r.rx_buf == $past(st_r.rx_sh[7:0])))
      else $error("push without receive-done");

   start_reload_a: assert property (
      start_det |=> (st_r.rx_timer == $past(baud_timer_reload_byte_in))
                    && (st_r.rx_state == unb_pkg::RX_START))
      else $error("receive timer not reloaded on start");

   rx_disabled_a: assert property (
      !st_r.rx_en |=> (st_r.rx_state == unb_pkg::RX_IDLE))
      else $error("receiver active while disabled");

   tick_halved_a: assert property (
      tx_tick |-> !($past(baud_timer_low_byte_ovf_in) && $past(st_r.tx_div)))
      else $error("transmit ticks on consecutive overflows");

   data_write_a: assert property (
      wr_data |=> st_r.tx_pend && (st_r.tx_hold[7:0] == $past(avs_writedata_in[7:0])))
      else $error("data write did not load transmit holding");

   tx_ninth_load_a: assert property (
      wr_data |=> st_r.tx_hold[8] == $past(st_r.tx_ninth_bit))
      else $error("ninth bit not taken at data write");

   tx_start_a: assert property (
      (st_r.tx_state == unb_pkg::TX_IDLE) && tx_tick && st_r.tx_pend
      |=> (st_r.tx_state == unb_pkg::TX_START) && !txd_out)
      else $error("pending byte did not start a frame");

   txd_steady_a: assert property (
      !tx_tick |=> $stable(txd_out))
      else $error("transmit line moved between bit ticks");

   tx_irq_raised_a: assert property (
      $rose(st_r.tx_done_flag) && st_r.int_en |-> irq_out)
      else $error("no interrupt on transmit-done");

   rx_ninth_status_a: assert property (
      push |=> st_r.rx_ninth_bit == ($past(st_r.ninth_bit_select) ? $past(st_r.rx_sh[8])
                                     : $past(st_r.rx_s2)))
      else $error("receive ninth status wrong");

   read_frees_a: assert property (
      rd_data && !push |=> !st_r.rx_full)
      else $error("buffer still full after data read");

   frame_sent_c: cover property (
      (st_r.tx_state == unb_pkg::TX_STOP) && st_r.ninth_bit_select);
   frame_pushed_c: cover property (push && st_r.ninth_bit_select);
   frame_dropped_c: cover property (push_try && st_r.rx_full);
   false_start_c: cover property (
      (st_r.rx_state == unb_pkg::RX_START) && rx_sample && st_r.rx_s2);
   filtered_c: cover property (push_try && st_r.addr_filter_enable && !frame_ninth);

endmodule

// ### unb_consts.svh
/*
 * Holds the register offsets, field positions and reset values of the
 * nine-bit serial port as macros.
 * Assumes it is included by bare name from the package and the module.
 */
`ifndef UNB_CONSTS_SVH
`define UNB_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ----------------------------------------------------------------------
`define UNB_ADDR_W 4
`define UNB_OFS_CTRL 4'h0
`define UNB_OFS_DATA 4'h4
`define UNB_OFS_PINCFG 4'h8

// ----------------------------------------------------------------------
// Field positions in serial_control_reg
// ----------------------------------------------------------------------
`define UNB_CTRL_RX_DONE 0
`define UNB_CTRL_TX_DONE 1
`define UNB_CTRL_RX_NINTH 2
`define UNB_CTRL_TX_NINTH 3
`define UNB_CTRL_RX_EN 4
`define UNB_CTRL_AFE 5
`define UNB_CTRL_INT_EN 6
`define UNB_CTRL_NINE_SEL 7

// ----------------------------------------------------------------------
// Field positions in rx_pin_config_reg, source codes and counts
// ----------------------------------------------------------------------
`define UNB_PCF_SRC_LO 0
`define UNB_PCF_SRC_HI 1
`define UNB_SRC_PIN 2'h0
`define UNB_SRC_CLU_A 2'h1
`define UNB_SRC_CLU_B 2'h2
`define UNB_SRC_CLU_C 2'h3
`define UNB_BITS_8 4'h8
`define UNB_BITS_9 4'h9
`define UNB_TIMER_TOP 8'hFF
`define UNB_RST_TXD 1'b1

`endif

// ### unb_pkg.sv
/*
 * Holds the types of the nine-bit serial port: state machine encodings
 * and the packed struct that carries all module state.
 * Assumes unb_consts.svh is on the include path.
 */
`include "unb_consts.svh"

package unb_pkg;

   // ----------------------------------------------------------------------
   // State machines
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} unb_tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} unb_rx_state_t;

   // ----------------------------------------------------------------------
   // All state of the port
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic rx_done_flag;
      logic tx_done_flag;
      logic rx_ninth_bit;
      logic tx_ninth_bit;
      logic rx_en;
      logic addr_filter_enable;
      logic int_en;
      logic ninth_bit_select;
      logic [1:0] rx_source_select;
      logic txd;
      unb_tx_state_t tx_state;
      logic tx_div;
      logic tx_pend;
      logic [8:0] tx_hold;
      logic [8:0] tx_sh;
      logic [3:0] tx_cnt;
      logic rx_s1;
      logic rx_s2;
      logic rx_prev;
      logic [7:0] rx_timer;
      logic rx_phase;
      unb_rx_state_t rx_state;
      logic [3:0] rx_cnt;
      logic [8:0] rx_sh;
      logic rx_full;
      logic [7:0] rx_buf;
   } unb_state_t;

endpackage

// ### unb_peer.sv
/*
 * Remote serial device model for the nine-bit serial port bench: sends
 * frames on the receive line and decodes frames seen on the transmit line.
 * Assumes one bit period is BIT cycles of mclk_in and the line idles high.
 */
`timescale 1ns/100ps

module unb_peer #(
   parameter int BIT = 16
) (
   input wire logic mclk_in,
   input wire logic txd_in,
   input wire logic nine_in,
   output logic line_out
);
   logic [8:0] rx_word;
   logic stop_bit;
   int rx_count = 0;
   int i;
   int k;

   initial line_out = 1'b1;

   // ----------------------------------------------------------------------
   // Frame sender: low start, bits LSB first, high stop
   // ----------------------------------------------------------------------
   task send(input logic [8:0] w, input logic nine);
      @(posedge mclk_in);
      line_out <= 1'b0;
      repeat (BIT) @(posedge mclk_in);
      for (k = 0; k < (nine ? 9 : 8); k++) begin
         line_out <= w[k];
         repeat (BIT) @(posedge mclk_in);
      end
      line_out <= 1'b1;
      repeat (BIT) @(posedge mclk_in);
   endtask

   // Frame decoder: samples mid-bit on the falling clock edge
   always begin
      @(negedge txd_in);
      repeat (BIT / 2) @(negedge mclk_in);
      rx_word = 9'h000;
      for (i = 0; i < (nine_in ? 9 : 8); i++) begin
         repeat (BIT) @(negedge mclk_in);
         rx_word[i] = txd_in;
      end
      repeat (BIT) @(negedge mclk_in);
      stop_bit = txd_in;
      rx_count++;
   end
endmodule

// ### tb_top.sv
/*
 * Self-checking bench of the nine-bit serial port: register bus master,
 * baud timer model, remote device model, transmit and receive scenarios.
 * Assumes the slave answers within fifty cycles; the timer can be stopped.
 */
`timescale 1ns/100ps
`include "unb_consts.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_top;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic ovf = 1'b0;
   logic run = 1'b1;
   logic nine = 1'b0;
   logic pl;
   logic wait_r;
   logic txd;
   logic irq;
   logic [3:0] addr = 4'h0;
   logic [3:0] be = 4'hF;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [31:0] q;
   logic [7:0] tl = 8'hF8;
   logic [1:0] src = 2'h0;
   logic [8:0] w;
   logic [7:0] d;
   logic t;
   int errors = 0;
   int cmp_count = 0;
   int c;
   int n;
   wire logic sel_pin = (src == 2'h0) ? pl : ~pl;
   wire logic [2:0] clu = {(src == 2'h3) ? pl : ~pl, (src == 2'h2) ? pl : ~pl,
                           (src == 2'h1) ? pl : ~pl};

   always #4 mclk_in = ~mclk_in;

   // Timer low byte model: overflow every eight counts while running
   always @(posedge mclk_in) begin
      if (run) tl <= (tl == 8'hFF) ? 8'hF8 : tl + 8'h01;
      ovf <= run && (tl == 8'hFF);
   end

   unb_uart i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
      .serial_rx_input_in(sel_pin), .clu_rx_in(clu), .timer_run_in(run),
      .timer_tick_in(1'b1), .baud_timer_low_byte_ovf_in(ovf),
      .baud_timer_reload_byte_in(8'hF8), .txd_out(txd), .irq_out(irq));

   unb_peer #(.BIT(16)) i_peer (.mclk_in(mclk_in), .txd_in(txd), .nine_in(nine),
      .line_out(pl));

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task give_verdict;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task timeout;
      errors++;
      $display("[FAIL] wait bound exhausted");
      give_verdict();
   endtask

   // One bus request held until waitrequest is sampled low at a rising edge
   task bus(input logic wn, input logic [3:0] a, input logic [31:0] dat,
            input logic [3:0] b);
      int m;
      @(posedge mclk_in);
      addr <= a;
      wdata <= dat;
      be <= b;
      wr <= wn;
      rd <= !wn;
      m = 0;
      @(posedge mclk_in);
      while (wait_r !== 1'b0) begin
         m++;
         if (m > 50) timeout();
         @(posedge mclk_in);
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task wait_irq(input logic v);
      int m;
      m = 0;
      while (irq !== v) begin
         @(negedge mclk_in);
         m++;
         if (m > 600) timeout();
      end
   endtask

   function logic [31:0] cw(logic nn, logic a, logic r, logic tn);
      return {24'h0, nn, 1'b1, a, r, tn, 3'b000};
   endfunction

   function logic [8:0] exp_word(logic [7:0] dd, logic tn, logic nn);
      return nn ? {tn, dd} : {1'b0, dd};
   endfunction

   // Send one frame from the peer and check what software sees
   task rx_one(input logic nn, input logic a, input logic r, input logic [8:0] ww,
               input logic acc);
      bus(1'b1, `UNB_OFS_CTRL, cw(nn, a, r, 1'b0), 4'hF);
      repeat ($urandom % 16) @(posedge mclk_in);
      i_peer.send(ww, nn);
      repeat (20) @(negedge mclk_in);
      bus(1'b0, `UNB_OFS_CTRL, 32'h0, 4'hF);
      `CHK("rx_done", acc, q[`UNB_CTRL_RX_DONE])
      if (acc) begin
         `CHK("rx_ninth", nn ? ww[8] : 1'b1, q[`UNB_CTRL_RX_NINTH])
         bus(1'b0, `UNB_OFS_DATA, 32'h0, 4'hF);
         `CHK("rx_byte", ww[7:0], q[7:0])
      end
      bus(1'b1, `UNB_OFS_CTRL, cw(nn, a, 1'b0, 1'b0), 4'hF);
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      void'($urandom(82040));
      repeat (12) @(posedge mclk_in);
      rst_in <= 1'b0;
      @(negedge mclk_in);
      `CHK("txd_reset", 1'b1, txd)
      `CHK("irq_reset", 1'b0, irq)
      for (int a = 0; a < 16; a += 4) begin
         bus(1'b0, a[3:0], 32'h0, 4'hF);
         `CHK("reset_read", 32'h0, q)
      end
      bus(1'b1, `UNB_OFS_CTRL, 32'hFF, 4'h0);
      bus(1'b0, `UNB_OFS_CTRL, 32'h0, 4'hF);
      `CHK("be_ignored", 32'h0, q)
      // Transmit in both modes with random data and ninth bit
      for (int i = 0; i < 8; i++) begin
         nine = i[0];
         t = 1'($urandom);
         d = 8'($urandom);
         bus(1'b1, `UNB_OFS_CTRL, cw(nine, 1'b0, 1'b0, t), 4'hF);
         c = i_peer.rx_count;
         bus(1'b1, `UNB_OFS_DATA, {24'h0, d}, 4'hF);
         wait_irq(1'b1);
         `CHK("tx_stop_start", 1'b1, txd)
         `CHK("tx_flag_early", c, i_peer.rx_count)
         bus(1'b0, `UNB_OFS_CTRL, 32'h0, 4'hF);
         `CHK("tx_flag_held", 1'b1, q[`UNB_CTRL_TX_DONE])
         n = 0;
         while (i_peer.rx_count == c) begin
            @(negedge mclk_in);
            n++;
            if (n > 600) timeout();
         end
         `CHK("tx_word", exp_word(d, t, nine), i_peer.rx_word)
         `CHK("tx_stop_bit", 1'b1, i_peer.stop_bit)
         bus(1'b1, `UNB_OFS_CTRL, cw(nine, 1'b0, 1'b0, t), 4'hF);
         @(negedge mclk_in);
         `CHK("irq_clear", 1'b0, irq)
      end
      // Receive random frames at random phase in both modes
      for (int i = 0; i < 8; i++) begin
         w = 9'($urandom);
         rx_one(i[0], 1'b0, 1'b1, w, 1'b1);
      end
      // Address filter table: 9-bit data, 9-bit address, 8-bit
      w = {1'b0, 8'h5A};
      rx_one(1'b1, 1'b1, 1'b1, w, 1'b0);
      w = {1'b1, 8'hA5};
      rx_one(1'b1, 1'b1, 1'b1, w, 1'b1);
      w = {1'b0, 8'h3C};
      rx_one(1'b0, 1'b1, 1'b1, w, 1'b1);
      // Receiver disabled ignores the line
      rx_one(1'b0, 1'b0, 1'b0, 9'h0C3, 1'b0);
      // Timer stopped: the hidden receive timer never samples
      run <= 1'b0;
      rx_one(1'b0, 1'b0, 1'b1, 9'h05A, 1'b0);
      run <= 1'b1;
      // Every receive source, back to the pin last
      for (int s = 1; s < 5; s++) begin
         bus(1'b1, `UNB_OFS_PINCFG, {30'h0, s[1:0]}, 4'hF);
         src <= s[1:0];
         rx_one(1'b0, 1'b0, 1'b1, {1'b0, 8'h96 ^ s[7:0]}, 1'b1);
      end
      // Buffer full keeps the first byte, frees on read
      bus(1'b1, `UNB_OFS_CTRL, cw(1'b0, 1'b0, 1'b1, 1'b0), 4'hF);
      i_peer.send(9'h011, 1'b0);
      i_peer.send(9'h0EE, 1'b0);
      repeat (20) @(negedge mclk_in);
      bus(1'b0, `UNB_OFS_DATA, 32'h0, 4'hF);
      `CHK("rx_full_keep", 8'h11, q[7:0])
      i_peer.send(9'h07E, 1'b0);
      repeat (20) @(negedge mclk_in);
      bus(1'b0, `UNB_OFS_DATA, 32'h0, 4'hF);
      `CHK("rx_after_read", 8'h7E, q[7:0])
      give_verdict();
   end
endmodule
